// File: logic/radio_mode_pkg.sv
// What this block does
// - two select pins choose mode zero, one, two
// - normal mode sends full fixed-length packets
// - three idle byte times flush short packet
// - indicator low on first byte, high after last send
// - buffer up to 512 bytes after start
// - receive: indicator low, wait 5ms, output bytes
// - wake mode prepends wake-up code per packet
// - wake mode receives exactly like normal mode
// - power-saving ignores serial input, transmits only a byte taken in the cycle the mode changes
// - power-saving polls air for wake-up code
// - power-saving capture: low, 5ms delay, output
// - after output return to polling cycle
// - wake-up time sets polling interval, latency
// - mode change applies 1ms after idle
package radio_mode_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned PACKET_BYTES  = 58;
  localparam int unsigned BACKLOG_BYTES = 512;
  localparam int unsigned GAP_BYTES     = 3;
  localparam int unsigned OUT_DELAY_US  = 5000;
  localparam int unsigned SWITCH_US     = 1000;
  localparam int unsigned MAX_LATENCY_MS = 2000;
  localparam int unsigned OUT_DELAY_CYC =
    OUT_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SWITCH_CYC = SWITCH_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MAX_POLL_CYC =
    MAX_LATENCY_MS * (CLK_HZ / 1000);
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_WAKE   = 2'h1;
  localparam logic [1:0] MODE_SAVE   = 2'h2;
  localparam logic [1:0] MODE_RESET  = 2'h0;
  localparam logic [7:0] WAKE_CODE   = 8'h55; // arbitrary preamble value
endpackage

// File: logic/skid_buffer.sv
`timescale 1ns/1ns
module skid_buffer #(
  parameter int unsigned WIDTH = 8
) (
  // clocking
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             clk_en,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_ff [2];
  logic [WIDTH-1:0] nxt_mem [2];
  logic [1:0]       cnt_ff, nxt_cnt;

  assign in_ready  = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data  = mem_ff[0];

  // two slots, head always at index zero
  always_comb begin
    logic push;
    logic pop;
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    nxt_mem = mem_ff;
    nxt_cnt = cnt_ff;
    if (pop) begin
      nxt_mem[0] = mem_ff[1];
    end
    if (push) begin
      nxt_mem[(pop ? cnt_ff - 2'h1 : cnt_ff) == 2'h0 ? 0 : 1] = in_data;
    end
    nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_ff    <= 2'h0;
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end else if (clk_en) begin
      cnt_ff <= nxt_cnt;
      mem_ff <= nxt_mem;
    end
  end
endmodule

// File: logic/radio_mode_packetizer.sv
`timescale 1ns/1ns
module radio_mode_packetizer #(
  parameter int unsigned PKT_LEN     = radio_mode_pkg::PACKET_BYTES,
  parameter int unsigned BACKLOG     = radio_mode_pkg::BACKLOG_BYTES,
  parameter int unsigned OUT_DLY_CYC = radio_mode_pkg::OUT_DELAY_CYC,
  parameter int unsigned SWITCH_CYC  = radio_mode_pkg::SWITCH_CYC
) (
  // clocking
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  // mode pins, asynchronous
  input  wire logic        mode_select_low_bit,
  input  wire logic        mode_select_high_bit,
  // configuration
  input  wire logic [23:0] byte_time_cyc,
  input  wire logic [7:0]  wake_code_len,
  input  wire logic [24:0] poll_interval_cyc,
  // serial bytes from host, already decoded
  input  wire logic        host_valid,
  output logic             host_ready,
  input  wire logic [7:0]  host_data,
  // bytes to radio
  output logic             air_tx_valid,
  input  wire logic        air_tx_ready,
  output logic      [7:0]  air_tx_data,
  output logic             air_tx_start,
  output logic             air_tx_wake,
  // bytes from radio
  input  wire logic        air_rx_valid,
  input  wire logic [7:0]  air_rx_data,
  input  wire logic        air_rx_last,
  input  wire logic        air_wake_seen,
  output logic             air_rx_listen,
  // bytes to host serial output
  output logic             host_tx_valid,
  input  wire logic        host_tx_ready,
  output logic      [7:0]  host_tx_data,
  // status
  output logic             activity_n,
  output logic      [1:0]  mode
);
  localparam int unsigned AW = $clog2(BACKLOG + PKT_LEN);
  localparam int unsigned DEPTH = BACKLOG + PKT_LEN;

  typedef enum logic [2:0] {
    ST_IDLE, ST_COLLECT, ST_WAKE, ST_SEND, ST_RXWAIT, ST_RXOUT
  } state_e;

  // pin synchronisers
  logic [1:0] pin_s1_ff, pin_s2_ff;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_s1_ff <= 2'h0;
      pin_s2_ff <= 2'h0;
    end else if (clk_en) begin
      pin_s1_ff <= {mode_select_high_bit, mode_select_low_bit};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  state_e            state_ff, nxt_state;
  logic [1:0]        mode_ff, nxt_mode;
  logic [23:0]       sw_cnt_ff, nxt_sw_cnt;
  logic [7:0]        buf_ff [DEPTH];
  logic [AW-1:0]     wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0]       used_ff, nxt_used;
  logic [23:0]       gap_ff, nxt_gap;
  logic [1:0]        gapn_ff, nxt_gapn;
  logic [7:0]        wk_ff, nxt_wk;
  logic [5:0]        sent_ff, nxt_sent;
  logic [24:0]       dly_ff, nxt_dly;
  logic [24:0]       poll_ff, nxt_poll;
  logic              act_n_ff, nxt_act_n;
  logic              start_ff, nxt_start;
  logic              rx_push, rx_ready, rx_done_ff, nxt_rx_done;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // host bytes only taken outside power saving and while room remains;
  // every handshake but air_rx_listen is masked while frozen, so no host, send or serial byte is lost or doubled; a radio byte arriving then is dropped
  logic host_take, tx_take, rx_take;
  assign host_ready = clk_en && (mode_ff != radio_mode_pkg::MODE_SAVE) &&
                      (used_ff < (AW+1)'(DEPTH)) &&
                      (state_ff == ST_IDLE || state_ff == ST_COLLECT ||
                       state_ff == ST_WAKE || state_ff == ST_SEND);
  assign host_take = host_valid && host_ready;
  assign tx_take   = air_tx_valid && air_tx_ready;
  assign air_tx_valid = clk_en &&
                        ((state_ff == ST_WAKE) ||
                         (state_ff == ST_SEND && used_ff != '0 &&
                          sent_ff != 6'(PKT_LEN)));
  assign air_tx_data  = (state_ff == ST_WAKE) ? radio_mode_pkg::WAKE_CODE
                                              : buf_ff[rd_ff];
  assign air_tx_wake  = (state_ff == ST_WAKE);
  assign air_tx_start = start_ff;
  // receiver always on except sleep part of the poll cycle
  assign air_rx_listen = (mode_ff != radio_mode_pkg::MODE_SAVE) ||
                         poll_ff == '0 || state_ff == ST_RXWAIT;
  assign activity_n = act_n_ff;
  assign mode = mode_ff;
  assign rx_push = clk_en && air_rx_valid && air_rx_listen && rx_ready &&
                   state_ff != ST_COLLECT && state_ff != ST_SEND &&
                   state_ff != ST_WAKE;
  assign rx_take = rx_push;

  // next state of the control path
  always_comb begin
    nxt_state = state_ff;
    nxt_mode = mode_ff;
    nxt_sw_cnt = sw_cnt_ff;
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_used = used_ff;
    nxt_gap = gap_ff;
    nxt_gapn = gapn_ff;
    nxt_wk = wk_ff;
    nxt_sent = sent_ff;
    nxt_dly = dly_ff;
    nxt_poll = poll_ff;
    nxt_act_n = act_n_ff;
    nxt_start = 1'b0;
    nxt_rx_done = rx_done_ff;
    if (host_take) begin
      nxt_wr = wrap_inc(wr_ff);
      nxt_gap = '0;
      nxt_gapn = '0;
    end
    if (tx_take && state_ff == ST_SEND) begin
      nxt_rd = wrap_inc(rd_ff);
      nxt_sent = sent_ff + 6'h1;
    end
    nxt_used = used_ff + (AW+1)'(host_take) -
               (AW+1)'(tx_take && state_ff == ST_SEND);
    // power-saving poll timer, counts down then listens
    if (mode_ff == radio_mode_pkg::MODE_SAVE && state_ff == ST_IDLE) begin
      // a wake code heard in the listen slot keeps the receiver open
      if (poll_ff == '0) begin
        nxt_poll = air_wake_seen ? '0 : poll_interval_cyc;
      end else begin
        nxt_poll = poll_ff - 25'h1;
      end
    end
    case (state_ff)
      ST_IDLE: begin
        // mode change only while idle and indicator high
        if (pin_s2_ff != mode_ff && pin_s2_ff != 2'h3) begin
          nxt_sw_cnt = sw_cnt_ff + 24'h1;
          if (sw_cnt_ff == 24'(SWITCH_CYC - 1)) begin
            nxt_mode = pin_s2_ff;
            nxt_sw_cnt = '0;
            nxt_poll = '0;
          end
        end else begin
          nxt_sw_cnt = '0;
        end
        if (host_take) begin
          nxt_state = ST_COLLECT;
          nxt_act_n = 1'b0;
          nxt_sw_cnt = '0;
        end else if (rx_push) begin
          nxt_state = ST_RXWAIT;
          nxt_sw_cnt = '0;
        end
      end
      ST_COLLECT: begin
        if (!host_take) begin
          nxt_gap = (gap_ff == byte_time_cyc - 24'h1) ? '0 : gap_ff + 24'h1;
          if (gap_ff == byte_time_cyc - 24'h1) begin
            nxt_gapn = gapn_ff + 2'h1;
          end
        end
        if (used_ff >= (AW+1)'(PKT_LEN) ||
            (gapn_ff == 2'(radio_mode_pkg::GAP_BYTES - 1) &&
             gap_ff == byte_time_cyc - 24'h1 && !host_take)) begin
          nxt_sent = '0;
          nxt_wk = wake_code_len;
          nxt_state = (mode_ff == radio_mode_pkg::MODE_WAKE &&
                       wake_code_len != '0) ? ST_WAKE : ST_SEND;
        end
      end
      ST_WAKE: begin
        if (tx_take) begin
          nxt_wk = wk_ff - 8'h1;
          if (wk_ff == 8'h1) begin
            nxt_state = ST_SEND;
          end
        end
      end
      ST_SEND: begin
        // a packet ends on full length or drained buffer
        if (sent_ff == 6'(PKT_LEN) || (used_ff == '0 && !host_take)) begin
          nxt_start = 1'b1;
          nxt_gap = '0;
          nxt_gapn = '0;
          if (nxt_used == '0) begin
            nxt_state = ST_IDLE;
            nxt_act_n = 1'b1;
          end else begin
            nxt_state = ST_COLLECT;
          end
        end
      end
      ST_RXWAIT: begin
        if (air_rx_valid && air_rx_last) begin
          nxt_rx_done = 1'b1;
        end
        if (rx_done_ff) begin
          nxt_act_n = 1'b0;
          nxt_dly = dly_ff + 25'h1;
          if (dly_ff == 25'(OUT_DLY_CYC - 1)) begin
            nxt_state = ST_RXOUT;
            nxt_dly = '0;
          end
        end
      end
      ST_RXOUT: begin
        if (!host_tx_valid) begin
          nxt_state = ST_IDLE;
          nxt_act_n = 1'b1;
          nxt_rx_done = 1'b0;
          nxt_poll = poll_interval_cyc;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // received bytes pass a two-entry buffer to the serial output
  logic       rb_valid;
  logic [7:0] rb_data;
  skid_buffer #(.WIDTH(8)) u_rx_buf (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .clk_en    (clk_en),
    .in_valid  (rx_take),
    .in_ready  (rx_ready),
    .in_data   (air_rx_data),
    .out_valid (rb_valid),
    .out_ready (host_tx_ready && state_ff == ST_RXOUT),
    .out_data  (rb_data)
  );
  assign host_tx_valid = clk_en && rb_valid &&
                         state_ff == ST_RXOUT;
  assign host_tx_data  = rb_data;

  // registers of the control path
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      mode_ff <= radio_mode_pkg::MODE_RESET;
      sw_cnt_ff <= '0;
      wr_ff <= '0;
      rd_ff <= '0;
      used_ff <= '0;
      gap_ff <= '0;
      gapn_ff <= '0;
      wk_ff <= '0;
      sent_ff <= '0;
      dly_ff <= '0;
      poll_ff <= '0;
      act_n_ff <= 1'b1;
      start_ff <= 1'b0;
      rx_done_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      sw_cnt_ff <= nxt_sw_cnt;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      used_ff <= nxt_used;
      gap_ff <= nxt_gap;
      gapn_ff <= nxt_gapn;
      wk_ff <= nxt_wk;
      sent_ff <= nxt_sent;
      dly_ff <= nxt_dly;
      poll_ff <= nxt_poll;
      act_n_ff <= nxt_act_n;
      start_ff <= nxt_start;
      rx_done_ff <= nxt_rx_done;
    end
  end

  // byte store, no reset needed for data
  always_ff @(posedge ref_clk) begin
    if (clk_en && host_take) begin
      buf_ff[wr_ff] <= host_data;
    end
  end
endmodule

// File: tb/packetizer_checker_assertions.sv
`timescale 1ns/1ns
module packetizer_checker (
  // watched ports
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       host_valid,
  input wire logic       host_ready,
  input wire logic       air_tx_valid,
  input wire logic       air_tx_ready,
  input wire logic [7:0] air_tx_data,
  input wire logic       air_tx_start,
  input wire logic       air_tx_wake,
  input wire logic       air_rx_valid,
  input wire logic       air_rx_last,
  input wire logic       air_rx_listen,
  input wire logic       host_tx_valid,
  input wire logic       host_tx_ready,
  input wire logic [7:0] host_tx_data,
  input wire logic       activity_n,
  input wire logic [1:0] mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // last radio byte taken, then a quiet busy spell before output
  sequence s_rx_end;
    air_rx_valid && air_rx_last && air_rx_listen;
  endsequence
  sequence s_quiet;
    (!activity_n && !host_tx_valid) [*8];
  endsequence
  a_rx_out_delay: assert property (s_rx_end |=> ##1 s_quiet)
    else $error("serial output began too early");
  a_save_no_host: assert property (mode == 2'h2 |-> !host_ready)
    else $error("host byte accepted in power saving");
  a_save_no_tx: assert property (mode == 2'h2 |-> !air_tx_valid)
    else $error("radio send in power saving");
  a_first_byte_low: assert property (
    host_valid && host_ready && activity_n |=> !activity_n)
    else $error("indicator not low after first byte");
  a_wake_code_only: assert property (air_tx_wake |->
    air_tx_valid && mode == 2'h1 && air_tx_data == radio_mode_pkg::WAKE_CODE)
    else $error("wake byte wrong or outside wake mode");
  a_tx_word_hold: assert property (
    air_tx_valid && !air_tx_ready |=> air_tx_valid && $stable(air_tx_data))
    else $error("radio byte lost in stall");
  a_out_word_hold: assert property (
    host_tx_valid && !host_tx_ready |=> host_tx_valid && $stable(host_tx_data))
    else $error("serial byte lost in stall");
  a_start_one_cycle: assert property (air_tx_start |=> !air_tx_start)
    else $error("start pulse too long");
  a_no_mode_three: assert property (mode != 2'h3)
    else $error("unsupported mode reported");
  a_mode_busy_hold: assert property (!activity_n |=> $stable(mode))
    else $error("mode changed while busy");
endmodule
// the checker rides on every packetizer instance
bind radio_mode_packetizer packetizer_checker chk (.ref_clk, .srst,
  .host_valid, .host_ready, .air_tx_valid, .air_tx_ready, .air_tx_data,
  .air_tx_start, .air_tx_wake, .air_rx_valid, .air_rx_last,
  .air_rx_listen, .host_tx_valid, .host_tx_ready, .host_tx_data,
  .activity_n, .mode);

// File: tb/radio_far_end.sv
`timescale 1ns/1ns
module radio_far_end (
  // transmit side
  input  wire logic       ref_clk,
  input  wire logic       air_tx_valid,
  input  wire logic [7:0] air_tx_data,
  input  wire logic       air_tx_wake,
  output logic            air_tx_ready,
  // receive side
  output logic            air_rx_valid,
  output logic [7:0]      air_rx_data,
  output logic            air_rx_last,
  input  wire logic       air_rx_listen,
  output logic            air_wake_seen
);
  logic [7:0] got[$];
  int         wakes;
  bit         slow;
  initial begin
    {air_tx_ready, air_rx_valid, air_rx_last, air_wake_seen, slow} = 0;
    wakes = 0;
    air_rx_data = 8'h00;
  end
  // collect payload apart from wake code; slow radio stalls at random
  always @(posedge ref_clk) begin
    if (air_tx_valid && air_tx_ready) begin
      if (air_tx_wake) wakes++;
      else got.push_back(air_tx_data);
    end
    #1 air_tx_ready <= slow ? 1'($urandom) : 1'b1;
  end
  // one packet; each byte held until the receiver listens at an edge
  task automatic send(input logic [7:0] b[$]);
    air_wake_seen <= 1'b1; // wake code flagged in the same cycle as the packet's first byte
    foreach (b[i]) begin
      air_rx_valid <= 1'b1;
      air_rx_data  <= b[i];
      air_rx_last  <= (i == b.size() - 1);
      @(posedge ref_clk);
      while (!air_rx_listen) @(posedge ref_clk);
      #1;
    end
    air_rx_valid <= 1'b0;
    air_rx_last  <= 1'b0;
    air_wake_seen <= 1'b0;
    air_rx_data  <= ~air_rx_data; // no stale byte on an idle air
  endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic       ref_clk = 1'b0;
  logic       srst = 1'b1;
  logic       clk_en = 1'b1;
  logic [1:0] sel = 2'h0;
  logic       host_valid = 1'b0;
  logic [7:0] host_data = 8'h00;
  logic       host_tx_ready = 1'b0;
  logic       host_ready, air_tx_valid, air_tx_ready, air_tx_start;
  logic       air_tx_wake, air_rx_valid, air_rx_last, air_rx_listen;
  logic       host_tx_valid, activity_n, air_wake_seen;
  logic [7:0] air_tx_data, air_rx_data, host_tx_data;
  logic [1:0] mode;
  logic [7:0] exp_air[$], exp_out[$], seen_out[$];
  int         mismatches, checks, cyc, n;
  // short delays keep the run brief
  radio_mode_packetizer #(.OUT_DLY_CYC(20), .SWITCH_CYC(10)) uut (
    .ref_clk, .srst, .clk_en, .mode_select_low_bit(sel[0]),
    .mode_select_high_bit(sel[1]), .byte_time_cyc(24'h000004),
    .wake_code_len(8'h02), .poll_interval_cyc(25'h0000006),
    .host_valid, .host_ready, .host_data, .air_tx_valid, .air_tx_ready,
    .air_tx_data, .air_tx_start, .air_tx_wake, .air_rx_valid,
    .air_rx_data, .air_rx_last, .air_wake_seen, .air_rx_listen,
    .host_tx_valid, .host_tx_ready, .host_tx_data, .activity_n, .mode);
  radio_far_end far (.ref_clk, .air_tx_valid, .air_tx_data, .air_tx_wake,
    .air_tx_ready, .air_rx_valid, .air_rx_data, .air_rx_last,
    .air_rx_listen, .air_wake_seen);
  initial forever #50 ref_clk = ~ref_clk;
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // compare a captured stream with the model, then empty both
  task automatic cmp_q(input string what, ref logic [7:0] got[$], e[$]);
    check({what, " count"}, 8'(got.size()), 8'(e.size()));
    while (got.size() && e.size()) check(what, got.pop_front(), e.pop_front());
    got = {};
    e = {};
  endtask
  task automatic host_send(input int cnt);
    repeat (cnt) begin
      host_valid <= 1'b1;
      host_data  <= 8'($urandom);
      @(posedge ref_clk);
      while (!host_ready) @(posedge ref_clk);
      exp_air.push_back(host_data);
      #1;
    end
    host_valid <= 1'b0;
  endtask
  task automatic wait_idle();
    n = 0;
    // the indicator falls two edges after a last radio byte
    repeat (2) @(posedge ref_clk);
    #1;
    while ((!activity_n || host_tx_valid || air_tx_valid) && n < 2000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("idle wait", {7'h0, n >= 2000}, 8'h00);
    check("idle indicator", {7'h0, activity_n}, 8'h01);
  endtask
  // host drains serial output with random stalls; hang guard
  always @(posedge ref_clk) begin
    if (host_tx_valid && host_tx_ready) seen_out.push_back(host_tx_data);
    if (++cyc == 40000) begin
      mismatches++;
      results();
    end
    #1 host_tx_ready <= 1'($urandom);
  end
  initial begin
    void'($urandom(37491));
    repeat (2) @(posedge ref_clk);
    #1 srst <= 1'b0;
    check("reset mode", {6'h0, mode}, 8'h00);
    check("reset ready", {7'h0, host_ready}, 8'h01);
    // a frozen block takes no byte however long the host waits
    clk_en <= 1'b0;
    host_valid <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1 check("frozen ready", {7'h0, host_ready}, 8'h00);
    check("frozen idle", {7'h0, activity_n}, 8'h01);
    clk_en <= 1'b1;
    host_valid <= 1'b0;
    @(posedge ref_clk);
    #1;
    // full packet plus remainder against a stalling radio
    far.slow = 1'b1;
    host_send(63);
    wait_idle();
    cmp_q("air full", far.got, exp_air);
    for (int m = 0; m < 3; m++) begin
      sel <= 2'(m);
      repeat (20) @(posedge ref_clk);
      #1 check("mode", {6'h0, mode}, 8'(m));
      far.wakes = 0;
      if (m < 2) begin
        host_send(5);
        check("busy", {7'h0, activity_n}, 8'h00);
      end else begin
        host_valid <= 1'b1;
        repeat (20) @(posedge ref_clk);
        #1 check("save ready", {7'h0, host_ready}, 8'h00);
        host_valid <= 1'b0;
      end
      wait_idle();
      cmp_q("air short", far.got, exp_air);
      check("wake bytes", 8'(far.wakes), m == 1 ? 8'h02 : 8'h00);
      // sender side runs in wake mode when this end saves power
      exp_out = {8'($urandom), 8'($urandom)};
      far.send(exp_out);
      wait_idle();
      cmp_q("serial out", seen_out, exp_out);
    end
    n = 0;
    while (!air_rx_listen && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    check("listen again", {7'h0, air_rx_listen}, 8'h01);
    results();
  end
endmodule
